// >>> core/pdp_pkg.sv
// package for the serially programmed divider chain and phase/frequency detector
// Behaviour
// - 16-bit frame ending with control bit high loads 15 bits into reference latch
// - prescaler divides 128/129 when modulus select is 0, 64/65 when 1
// - 19-bit frame ending with control bit low loads 18 bits into main latch
// - swallow count is 7 bits in the lowest latch positions, range 0 to 127
// - divided VCO period is P*N+A input cycles; host keeps A below N
// - 14-bit reference counter divides oscillator by latched reference divisor
// - one data bit shifts in on each serial clock rising edge
// - detector acts only on leading edges of both divided signals
// - polarity high, VCO faster: VCO-side drive high, reference-side pulses high
// - polarity high, VCO slower: reference-side drive low, VCO-side pulses low
// - polarity low swaps the two non-locked responses
// - in lock VCO-side drive stays high, reference-side low, except spikes
// - correction pulse widens with phase error, at least half duty at 180 degrees
// - out of lock, polarity select inverts both drives and the internal pump together
// - compared edges in phase still give short spikes, removing the dead band
// - shift register moves to selected latch while load strobe is high
// - lock flag is NOR of detector up and down, idles high
// - monitor carries divided reference when polarity high, divided VCO when low
// - bypass pump follows internal pump while strobe high, else high impedance
package pdp_pkg;
   localparam int REF_DIV_W = 14;
   localparam int MAIN_DIV_W = 11;
   localparam int SWALLOW_W = 7;
   localparam int SHIFT_W = 19;
   localparam int PRESC_W = 8;
   // frame field positions, control bit in position 0
   localparam int CTRL_POS = 0;
   localparam int REF_LSB = 1;
   localparam int MAIN_LSB = 1;
   localparam logic [PRESC_W-1:0] PRESC_LARGE = 8'h80;
   localparam logic [PRESC_W-1:0] PRESC_SMALL = 8'h40;
   localparam logic [REF_DIV_W-1:0] REF_DIV_RST = 14'h0008;
   localparam logic [MAIN_DIV_W-1:0] MAIN_DIV_RST = 11'h010;
   localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 7'h00;
   localparam logic PRESC_SEL_RST = 1'b0;

   typedef struct packed {
      logic [REF_DIV_W-1:0] ref_div;
      logic presc_sel;
   } pdp_ref_latch_t;

   typedef struct packed {
      logic [MAIN_DIV_W-1:0] main_div;
      logic [SWALLOW_W-1:0] swallow;
   } pdp_main_latch_t;

   localparam pdp_ref_latch_t REF_LATCH_RST = '{ref_div: REF_DIV_RST, presc_sel: PRESC_SEL_RST};
   localparam pdp_main_latch_t MAIN_LATCH_RST = '{main_div: MAIN_DIV_RST, swallow: SWALLOW_RST};
endpackage : pdp_pkg

// >>> core/pdp_top.sv
// serial programming, dividers, phase/frequency detector and pump drives
`timescale 1ns/100ps
module pdp_top (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ser_data,
   input wire logic i_ser_clk,
   input wire logic i_latch_load_strobe,
   input wire logic i_phase_polarity_select,
   input wire logic i_ref_osc,
   input wire logic i_vco_in,
   output logic o_phase_ref_drive,
   output logic o_phase_vco_drive,
   output logic o_pump_out,
   output logic o_pump_oe,
   output logic o_bypass_pump_output,
   output logic o_bypass_pump_output_oe,
   output logic o_lock_flag_out,
   output logic o_divider_monitor,
   output pdp_pkg::pdp_ref_latch_t o_ref_latch,
   output pdp_pkg::pdp_main_latch_t o_main_latch
);
   import pdp_pkg::*;

   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction : rise

   logic ser_clk_q_ff, ref_osc_q_ff, vco_q_ff;
   logic [SHIFT_W-1:0] shift_ff;
   pdp_ref_latch_t ref_latch_ff;
   pdp_main_latch_t main_latch_ff;
   logic [REF_DIV_W-1:0] ref_cnt_ff;
   logic [PRESC_W-1:0] presc_cnt_ff;
   logic [MAIN_DIV_W-1:0] main_cnt_ff;
   logic [SWALLOW_W-1:0] swallow_cnt_ff;
   logic divided_reference_ff, divided_vco_ff, fr_q_ff, fp_q_ff;
   logic vco_lead_ff, ref_lead_ff;

   wire ser_edge = rise(i_ser_clk, ser_clk_q_ff);
   wire ref_edge = rise(i_ref_osc, ref_osc_q_ff);
   wire vco_edge = rise(i_vco_in, vco_q_ff);
   wire fr_edge = rise(divided_reference_ff, fr_q_ff);
   wire fp_edge = rise(divided_vco_ff, fp_q_ff);
   wire ctrl_bit = shift_ff[CTRL_POS];
   wire load_ref = i_latch_load_strobe & ctrl_bit;
   wire load_main = i_latch_load_strobe & ~ctrl_bit;
   wire pdp_ref_latch_t shift_ref = shift_ff[REF_LSB +: $bits(pdp_ref_latch_t)];
   wire pdp_main_latch_t shift_main = shift_ff[MAIN_LSB +: $bits(pdp_main_latch_t)];
   wire ref_wrap = ref_edge && (ref_cnt_ff <= 14'h0001);
   wire [PRESC_W-1:0] presc_base = ref_latch_ff.presc_sel ? PRESC_SMALL : PRESC_LARGE;
   wire swallowing = (swallow_cnt_ff != 7'h00);
   wire [PRESC_W-1:0] presc_last = swallowing ? presc_base : presc_base - 8'h01;
   wire presc_wrap = vco_edge && (presc_cnt_ff == presc_last);
   wire main_wrap = presc_wrap && (main_cnt_ff <= 11'h001);
   // a fresh edge wins over the spike clear so that no compared edge is lost
   wire nxt_vco_lead = fp_edge | (vco_lead_ff & ~(vco_lead_ff & ref_lead_ff));
   wire nxt_ref_lead = fr_edge | (ref_lead_ff & ~(vco_lead_ff & ref_lead_ff));
   wire pol = i_phase_polarity_select;
   wire nxt_phase_ref = pol ? vco_lead_ff : ref_lead_ff;
   wire nxt_phase_vco = pol ? ~ref_lead_ff : ~vco_lead_ff;
   wire pump_active = vco_lead_ff ^ ref_lead_ff;
   wire nxt_pump_val = pol ? ref_lead_ff : vco_lead_ff;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ser_clk_q_ff <= 1'b0;
         ref_osc_q_ff <= 1'b0;
         vco_q_ff <= 1'b0;
         shift_ff <= '0;
         fr_q_ff <= 1'b0;
         fp_q_ff <= 1'b0;
      end else begin
         ser_clk_q_ff <= i_ser_clk;
         ref_osc_q_ff <= i_ref_osc;
         vco_q_ff <= i_vco_in;
         if (ser_edge) begin
            shift_ff <= {shift_ff[SHIFT_W-2:0], i_ser_data};
         end
         fr_q_ff <= divided_reference_ff;
         fp_q_ff <= divided_vco_ff;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ref_latch_ff <= REF_LATCH_RST;
         main_latch_ff <= MAIN_LATCH_RST;
      end else begin
         if (load_ref) begin
            ref_latch_ff <= shift_ref;
         end
         if (load_main) begin
            main_latch_ff <= shift_main;
         end
      end
   end

   // reference divider: counts oscillator edges down from the divisor
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ref_cnt_ff <= REF_DIV_RST;
         divided_reference_ff <= 1'b0;
      end else begin
         if (ref_wrap) begin
            ref_cnt_ff <= ref_latch_ff.ref_div;
         end else if (ref_edge) begin
            ref_cnt_ff <= ref_cnt_ff - 14'h0001;
         end
         divided_reference_ff <= ref_cnt_ff > (ref_latch_ff.ref_div >> 1);
      end
   end

   // pulse swallow: first A prescaler cycles run at P+1, the rest at P
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         presc_cnt_ff <= '0;
         main_cnt_ff <= MAIN_DIV_RST;
         swallow_cnt_ff <= SWALLOW_RST;
         divided_vco_ff <= 1'b0;
      end else begin
         if (presc_wrap) begin
            presc_cnt_ff <= '0;
         end else if (vco_edge) begin
            presc_cnt_ff <= presc_cnt_ff + 8'h01;
         end
         if (main_wrap) begin
            main_cnt_ff <= main_latch_ff.main_div;
            swallow_cnt_ff <= main_latch_ff.swallow;
         end else if (presc_wrap) begin
            main_cnt_ff <= main_cnt_ff - 11'h001;
            swallow_cnt_ff <= swallowing ? swallow_cnt_ff - 7'h01 : swallow_cnt_ff;
         end
         divided_vco_ff <= main_cnt_ff > (main_latch_ff.main_div >> 1);
      end
   end

   // detector: a lead flag stays set from its edge until the other edge arrives,
   // so the pulse width tracks phase error; both set for one cycle is the spike
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         vco_lead_ff <= 1'b0;
         ref_lead_ff <= 1'b0;
      end else begin
         vco_lead_ff <= nxt_vco_lead;
         ref_lead_ff <= nxt_ref_lead;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_phase_ref_drive <= 1'b0;
         o_phase_vco_drive <= 1'b1;
         o_pump_out <= 1'b0;
         o_pump_oe <= 1'b0;
         o_bypass_pump_output <= 1'b0;
         o_bypass_pump_output_oe <= 1'b0;
         o_lock_flag_out <= 1'b1;
         o_divider_monitor <= 1'b0;
         o_ref_latch <= REF_LATCH_RST;
         o_main_latch <= MAIN_LATCH_RST;
      end else begin
         o_phase_ref_drive <= nxt_phase_ref;
         o_phase_vco_drive <= nxt_phase_vco;
         o_pump_out <= nxt_pump_val;
         o_pump_oe <= pump_active;
         o_bypass_pump_output <= nxt_pump_val;
         o_bypass_pump_output_oe <= pump_active & i_latch_load_strobe;
         o_lock_flag_out <= ~(vco_lead_ff | ref_lead_ff);
         o_divider_monitor <= pol ? divided_reference_ff : divided_vco_ff;
         o_ref_latch <= ref_latch_ff;
         o_main_latch <= main_latch_ff;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   property p_shift;
      ser_edge |=> shift_ff[0] == $past(i_ser_data) && shift_ff[1] == $past(shift_ff[0]);
   endproperty
   a_shift: assert property (p_shift) else $error("shift missed a bit");

   property p_ref_load;
      load_ref |=> ref_latch_ff == $past(shift_ref);
   endproperty
   a_ref_load: assert property (p_ref_load) else $error("reference latch not loaded");

   property p_main_load;
      load_main |=> main_latch_ff == $past(shift_main) ##1 o_main_latch == $past(shift_main, 2);
   endproperty
   a_main_load: assert property (p_main_load) else $error("main latch not loaded");

   property p_ref_reload;
      ref_wrap |=> ref_cnt_ff == $past(ref_latch_ff.ref_div);
   endproperty
   a_ref_reload: assert property (p_ref_reload) else $error("reference counter reload");

   property p_presc_mod;
      presc_wrap && !swallowing |->
         presc_cnt_ff == (ref_latch_ff.presc_sel ? PRESC_SMALL : PRESC_LARGE) - 8'h01;
   endproperty
   a_presc_mod: assert property (p_presc_mod) else $error("prescaler modulus wrong");

   property p_spike;
      vco_lead_ff && ref_lead_ff && !fp_edge && !fr_edge |=>
         !vco_lead_ff && !ref_lead_ff ##1 o_lock_flag_out;
   endproperty
   a_spike: assert property (p_spike) else $error("coincident spike not cleared");

   property p_fast_vco;
      pol && vco_lead_ff && !ref_lead_ff |=> o_phase_ref_drive && o_phase_vco_drive && !o_pump_out;
   endproperty
   a_fast_vco: assert property (p_fast_vco) else $error("fast vco response wrong");

   property p_slow_vco;
      !pol && ref_lead_ff && !vco_lead_ff |=> o_phase_ref_drive && o_phase_vco_drive;
   endproperty
   a_slow_vco: assert property (p_slow_vco) else $error("swapped response wrong");

   property p_lock;
      !vco_lead_ff && !ref_lead_ff |=> o_lock_flag_out && !o_phase_ref_drive && o_phase_vco_drive;
   endproperty
   a_lock: assert property (p_lock) else $error("locked drives wrong");

   property p_monitor;
      pol |=> o_divider_monitor == $past(divided_reference_ff);
   endproperty
   a_monitor: assert property (p_monitor) else $error("monitor source wrong");

   property p_bypass;
      !i_latch_load_strobe |=> !o_bypass_pump_output_oe;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not released");

   property p_slow_ref;
      pol && ref_lead_ff && !vco_lead_ff |=> !o_phase_ref_drive && !o_phase_vco_drive && o_pump_out;
   endproperty
   a_slow_ref: assert property (p_slow_ref) else $error("slow vco response wrong");

   property p_fast_rev;
      !pol && vco_lead_ff && !ref_lead_ff |=> !o_phase_ref_drive && !o_phase_vco_drive && o_pump_out;
   endproperty
   a_fast_rev: assert property (p_fast_rev) else $error("reversed fast response wrong");

   property p_pump_on;
      vco_lead_ff != ref_lead_ff |=> o_pump_oe;
   endproperty
   a_pump_on: assert property (p_pump_on) else $error("pump not driving");

   property p_pump_off;
      vco_lead_ff == ref_lead_ff |=> !o_pump_oe;
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump driving in lock");

   property p_bypass_follow;
      i_latch_load_strobe && (vco_lead_ff != ref_lead_ff) |=>
         o_bypass_pump_output_oe && o_bypass_pump_output == o_pump_out;
   endproperty
   a_bypass_follow: assert property (p_bypass_follow) else $error("bypass not following");

   property p_monitor_vco;
      !pol |=> o_divider_monitor == $past(divided_vco_ff);
   endproperty
   a_monitor_vco: assert property (p_monitor_vco) else $error("monitor vco source wrong");

   property p_lock_low;
      vco_lead_ff || ref_lead_ff |=> !o_lock_flag_out;
   endproperty
   a_lock_low: assert property (p_lock_low) else $error("lock flag not low");

   property p_main_reload;
      main_wrap |=> main_cnt_ff == $past(main_latch_ff.main_div)
         && swallow_cnt_ff == $past(main_latch_ff.swallow);
   endproperty
   a_main_reload: assert property (p_main_reload) else $error("main counter reload");

   property p_swallow_step;
      presc_wrap && !main_wrap && swallowing |=> swallow_cnt_ff == $past(swallow_cnt_ff) - 7'h01;
   endproperty
   a_swallow_step: assert property (p_swallow_step) else $error("swallow step wrong");

   property p_ref_latch_out;
      load_ref |=> ##1 o_ref_latch == $past(shift_ref, 2);
   endproperty
   a_ref_latch_out: assert property (p_ref_latch_out) else $error("ref latch copy wrong");

   property p_shift_hold;
      !ser_edge |=> $stable(shift_ff);
   endproperty
   a_shift_hold: assert property (p_shift_hold) else $error("shift without clock");

   property p_ref_count;
      ref_edge && !ref_wrap |=> ref_cnt_ff == $past(ref_cnt_ff) - 14'h0001;
   endproperty
   a_ref_count: assert property (p_ref_count) else $error("reference count step");

   property p_vco_set;
      fp_edge |=> vco_lead_ff;
   endproperty
   a_vco_set: assert property (p_vco_set) else $error("vco edge lost");

   property p_ref_set;
      fr_edge |=> ref_lead_ff;
   endproperty
   a_ref_set: assert property (p_ref_set) else $error("reference edge lost");

   property p_presc_swallow;
      presc_wrap && swallowing |->
         presc_cnt_ff == (ref_latch_ff.presc_sel ? PRESC_SMALL : PRESC_LARGE);
   endproperty
   a_presc_swallow: assert property (p_presc_swallow) else $error("swallow modulus wrong");

   property p_presc_step;
      vco_edge && !presc_wrap |=> presc_cnt_ff == $past(presc_cnt_ff) + 8'h01;
   endproperty
   a_presc_step: assert property (p_presc_step) else $error("prescaler step wrong");

   c_ref_load: cover property (load_ref ##1 ref_wrap);
   c_main_wrap: cover property (main_wrap);
   c_vco_lead: cover property (vco_lead_ff [*3]);
   c_coincident: cover property (fp_edge && fr_edge);
endmodule : pdp_top

// >>> verif/pdp_host_model.sv
// host model that shifts programming frames over the three-wire link
`timescale 1ns/100ps
module pdp_host_model (
   input wire logic i_clk,
   output logic o_ser_data,
   output logic o_ser_clk,
   output logic o_strobe
);
   initial begin
      o_ser_data = 1'b0;
      o_ser_clk = 1'b0;
      o_strobe = 1'b0;
   end
   // serial clock stands low between frames; data inverts once its hold is over
   task automatic send(input int n, input logic [18:0] f);
      for (int i = n - 1; i >= 0; i--) begin
         o_ser_data = f[i];
         repeat (2) @(negedge i_clk);
         o_ser_clk = 1'b1;
         repeat (2) @(negedge i_clk);
         o_ser_clk = 1'b0;
         o_ser_data = ~f[i];
         @(negedge i_clk);
      end
      o_strobe = 1'b1;
      repeat (3) @(negedge i_clk);
      o_strobe = 1'b0;
      @(negedge i_clk);
   endtask : send
   // callers keep divisors legal: reference 8 and up
   task automatic load_ref(input logic [13:0] r, input logic sel);
      send(16, {3'h0, r, sel, 1'b1});
   endtask : load_ref
   // callers keep main divisor 16 and up and swallow below it
   task automatic load_main(input logic [10:0] n, input logic [6:0] a);
      send(19, {n, a, 1'b0});
   endtask : load_main
   task automatic strobe(input logic v);
      o_strobe = v;
      @(negedge i_clk);
   endtask : strobe
endmodule : pdp_host_model

// >>> verif/pdp_top_tb.sv
// self-checking bench for the divider chain and phase detector
`timescale 1ns/100ps
module pdp_top_tb;
   import pdp_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic pol = 1'b1;
   logic osc = 1'b0;
   logic vco = 1'b0;
   logic sd, sc, le, rd, vd, po, poe, bp, bpoe, lk, mon;
   pdp_ref_latch_t rl;
   pdp_main_latch_t ml;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   int a, b, c, e;
   always #2 clk = ~clk;
   always @(posedge clk) cyc++;
   always @(negedge clk) osc <= ~osc;
   always @(negedge clk) vco <= ~vco;
   pdp_host_model u_host (.i_clk(clk), .o_ser_data(sd), .o_ser_clk(sc), .o_strobe(le));
   pdp_top DUT (.i_clk(clk), .i_srst(srst), .i_ser_data(sd), .i_ser_clk(sc),
      .i_latch_load_strobe(le), .i_phase_polarity_select(pol), .i_ref_osc(osc),
      .i_vco_in(vco), .o_phase_ref_drive(rd), .o_phase_vco_drive(vd), .o_pump_out(po),
      .o_pump_oe(poe), .o_bypass_pump_output(bp), .o_bypass_pump_output_oe(bpoe),
      .o_lock_flag_out(lk), .o_divider_monitor(mon), .o_ref_latch(rl), .o_main_latch(ml));
   task automatic wrap_up;
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic rise;
      int k;
      k = 0;
      while (mon === 1'b1 && k < 9000) begin
         @(negedge clk);
         k++;
      end
      while (mon !== 1'b1 && k < 9000) begin
         @(negedge clk);
         k++;
      end
   endtask : rise
   // skip the period still running on the old divisor
   task automatic per(input int exp);
      int k;
      rise();
      rise();
      k = cyc;
      rise();
      chk(cyc - k, exp, "monitor period");
   endtask : per
   task automatic watch(input int n);
      a = 0;
      b = 0;
      c = 0;
      e = 0;
      repeat (n) begin
         @(negedge clk);
         a += int'(rd === 1'b1);
         b += int'(vd === 1'b1);
         c += int'(lk === 1'b1);
         e += int'(bpoe !== (poe & le) || (bpoe === 1'b1 && bp !== po));
      end
   endtask : watch
   initial begin
      #320000;
      failures++;
      wrap_up();
   end
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      chk(rl, REF_LATCH_RST, "ref latch reset");
      chk(ml, MAIN_LATCH_RST, "main latch reset");
      chk({vd, rd, lk, poe, bpoe}, 5'b10100, "idle outputs");
      u_host.load_main(11'h010, 7'h03);
      u_host.load_ref(14'h0008, 1'b1);
      chk(rl, {14'h0008, 1'b1}, "ref latch load");
      chk(ml, {11'h010, 7'h03}, "main latch load");
      per(16);
      pol = 1'b0;
      per(2054);
      // divided vco much slower than divided reference
      watch(4000);
      chk(a > 2000, 1, "reversed ref drive");
      chk(b > 3960, 1, "reversed vco drive");
      chk(c < 2000, 1, "lock flag");
      chk(e, 0, "bypass released");
      pol = 1'b1;
      watch(4000);
      chk(a < 40, 1, "ref drive low");
      chk(b < 2000, 1, "vco drive pulses");
      u_host.load_ref(14'h3FFF, 1'b0);
      chk(rl, {14'h3FFF, 1'b0}, "ref latch max");
      pol = 1'b0;
      per(4102);
      // divided vco much faster, bypass switched on
      pol = 1'b1;
      u_host.strobe(1'b1);
      watch(32766);
      chk(a > 16383, 1, "ref drive pulses");
      chk(b > 24574, 1, "vco drive high");
      chk(e, 0, "bypass follows pump");
      u_host.strobe(1'b0);
      wrap_up();
   end
endmodule : pdp_top_tb
